// [design/hpc_regs.sv]
`timescale 1ns/1ps
`include "hpc_map.svh"
module hpc_regs (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Configuration source, straps and OTP bits
  input  wire hpc_pkg::hpc_src_type src_mode,
  input  wire logic [3:0]         power_charge_strap_pins,
  input  wire logic [3:0]         otp_non_removable,
  // Register access
  input  wire hpc_pkg::hpc_wr_type wr_req,
  input  wire hpc_pkg::hpc_rd_type rd_req,
  output logic [7:0]              rd_data,
  // Configuration outputs
  output logic [3:0]              charge_port_enable,
  output logic [3:0]              port_removable,
  output logic                    removable_override,
  output logic [3:0]              port_in_use,
  output logic [7:0]              device_config_second
);
  import hpc_pkg::*;

  // ==========================================================
  // Strap capture state
  logic       strap_ff;
  logic       nxt_strap;
  // Charge enable state
  logic [3:0] charge_ff;
  logic [3:0] nxt_charge;
  // Removable state
  logic       ovr_ff;
  logic       nxt_ovr;
  logic [3:0] rmbl_ff;
  logic [3:0] nxt_rmbl;
  // Port-used state
  logic [3:0] used_ff;
  logic [3:0] nxt_used;
  // Second device configuration state
  logic [7:0] cfg2_ff;
  logic [7:0] nxt_cfg2;
  // Read data state
  logic [7:0] rdat_ff;
  logic [7:0] nxt_rdat;
  // Qualified write strobes per register
  logic       wr_ok;
  logic       hit_charge;
  logic       hit_removable;
  logic       hit_in_use;
  logic       hit_cfg2;

  // ==========================================================
  // Write address decode
  function automatic logic write_hit(input logic       ok,
                                     input logic [7:0] addr,
                                     input logic [7:0] ofs);
    return ok && (addr == ofs);
  endfunction : write_hit

  // Register read view, reserved bits read zero
  function automatic logic [7:0] read_view(input logic [7:0] addr, input logic [3:0] chg,
                                           input logic ovr, input logic [3:0] rmv,
                                           input logic [3:0] usd, input logic [7:0] c2);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      `HPC_OFS_CHARGE:    v = {4'h0, chg};
      `HPC_OFS_REMOVABLE: v = {ovr, 3'h0, rmv};
      `HPC_OFS_IN_USE:    v = {4'h0, usd};
      `HPC_OFS_DEVCFG2:   v = c2;
      default:            v = 8'h00;
    endcase
    return v;
  endfunction : read_view

  // ==========================================================
  // Write qualification
  // Writes are refused while the straps own the configuration
  assign wr_ok         = wr_req.wr && (src_mode != HPC_SRC_PINS);
  assign hit_charge    = write_hit(wr_ok, wr_req.addr, `HPC_OFS_CHARGE);
  assign hit_removable = write_hit(wr_ok, wr_req.addr, `HPC_OFS_REMOVABLE);
  assign hit_in_use    = write_hit(wr_ok, wr_req.addr, `HPC_OFS_IN_USE);
  assign hit_cfg2      = write_hit(wr_ok, wr_req.addr, `HPC_OFS_DEVCFG2);

  // ==========================================================
  // Strap capture
  // The flag only stands for the first edge after reset release
  always_comb begin
    nxt_strap = 1'b0;
  end

  // Strap flag register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_ff <= 1'b1;
    end else begin
      strap_ff <= nxt_strap;
    end
  end

  // ==========================================================
  // Charge enables
  // Straps load first, a qualified write in that cycle wins
  always_comb begin
    nxt_charge = charge_ff;
    if (strap_ff) begin
      nxt_charge = power_charge_strap_pins;
    end
    if (hit_charge) begin
      nxt_charge = wr_req.data[`HPC_PORT_MSB:0];
    end
  end

  // Charge enable register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      charge_ff <= `HPC_CHARGE_RST;
    end else begin
      charge_ff <= nxt_charge;
    end
  end

  // ==========================================================
  // Removable field and override
  // Override and field may land in one write
  always_comb begin
    nxt_ovr  = ovr_ff;
    nxt_rmbl = rmbl_ff;
    if (hit_removable) begin
      nxt_ovr = wr_req.data[`HPC_OVERRIDE_BIT];
      if (wr_req.data[`HPC_OVERRIDE_BIT]) begin
        nxt_rmbl = wr_req.data[`HPC_PORT_MSB:0];
      end
    end
    // Read-only view of the inverted OTP bits while override is clear
    if (!nxt_ovr) begin
      nxt_rmbl = ~otp_non_removable;
    end
  end

  // Removable registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovr_ff  <= `HPC_OVR_RST;
      rmbl_ff <= `HPC_RMBL_RST;
    end else begin
      ovr_ff  <= nxt_ovr;
      rmbl_ff <= nxt_rmbl;
    end
  end

  // ==========================================================
  // Port-used field
  // Keeping ports 1 and 3 from both being disabled is the host's duty
  always_comb begin
    nxt_used = used_ff;
    if (hit_in_use) begin
      nxt_used = wr_req.data[`HPC_PORT_MSB:0];
    end
  end

  // Port-used register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      used_ff <= `HPC_IN_USE_RST;
    end else begin
      used_ff <= nxt_used;
    end
  end

  // ==========================================================
  // Second device configuration
  // Fields are kept as one full read/write byte
  always_comb begin
    nxt_cfg2 = cfg2_ff;
    if (hit_cfg2) begin
      nxt_cfg2 = wr_req.data;
    end
  end

  // Second device configuration register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg2_ff <= `HPC_DEVCFG2_RST;
    end else begin
      cfg2_ff <= nxt_cfg2;
    end
  end

  // ==========================================================
  // Read data
  // A read in the cycle of a write returns the new value
  always_comb begin
    nxt_rdat = rdat_ff;
    if (rd_req.rd) begin
      nxt_rdat = read_view(rd_req.addr, nxt_charge, nxt_ovr, nxt_rmbl,
                           nxt_used, nxt_cfg2);
    end
  end

  // Read data register, holds until the next read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdat_ff <= `HPC_RDATA_RST;
    end else begin
      rdat_ff <= nxt_rdat;
    end
  end

  // ==========================================================

  // Outputs straight from flip-flops
  assign rd_data              = rdat_ff;
  assign charge_port_enable   = charge_ff;
  assign port_removable       = rmbl_ff;
  assign removable_override   = ovr_ff;
  assign port_in_use          = used_ff;
  assign device_config_second = cfg2_ff;
endmodule : hpc_regs

// [inc/hpc_map.svh]
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH
// ==========================================================
// Register offsets
`define HPC_OFS_CHARGE    8'h06
`define HPC_OFS_REMOVABLE 8'h07
`define HPC_OFS_IN_USE    8'h08
`define HPC_OFS_DEVCFG2   8'h0A
// ==========================================================
// Field positions
`define HPC_OVERRIDE_BIT  7
`define HPC_PORT_MSB      3
// ==========================================================
// Reset values
`define HPC_IN_USE_RST    4'hF
`define HPC_DEVCFG2_RST   8'h00
`define HPC_CHARGE_RST    4'h0
`define HPC_OVR_RST       1'h0
`define HPC_RMBL_RST      4'h0
`define HPC_RDATA_RST     8'h00
`endif

// [inc/hpc_pkg.sv]
package hpc_pkg;
  // ==========================================================
  // Register write request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } hpc_wr_type;
  // Register read request
  typedef struct packed {
    logic       rd;
    logic [7:0] addr;
  } hpc_rd_type;
  // Configuration source mode
  typedef enum logic [1:0] {
    HPC_SRC_PINS,
    HPC_SRC_EEPROM,
    HPC_SRC_SMBUS
  } hpc_src_type;
endpackage : hpc_pkg

// [tb/hpc_host.sv]
`timescale 1ns/1ps
// ======
// Host model
module hpc_host (
  // Bus
  input wire logic clk,
  output hpc_pkg::hpc_wr_type w,
  output hpc_pkg::hpc_rd_type r
);
  initial {w, r} = 0;
  // One-cycle strobe, then an idle pattern
  task x(input logic we, input logic [7:0] a, d);
    if (we && a == 8'h08) d[0] |= ~d[2];
    w = {we, a, d};
    r = {!we, a};
    @(posedge clk) #1;
    w = {1'b0, ~a, ~d};
    r = {1'b0, ~a};
    // Let one edge pass before the next request
    @(posedge clk) #1;
  endtask : x
endmodule : hpc_host

// [tb/hpc_regs_monitor.sv]
`timescale 1ns/1ps
// ======
// Port checks
module hpc_regs_mon (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 sys_rst,
  // Requests and levels
  input wire hpc_pkg::hpc_src_type src_mode,
  input wire hpc_pkg::hpc_wr_type  wr_req,
  input wire hpc_pkg::hpc_rd_type  rd_req,
  input wire logic [3:0]           power_charge_strap_pins,
  input wire logic [3:0]           otp_non_removable,
  // Watched outputs
  input wire logic [3:0]           charge_port_enable,
  input wire logic [3:0]           port_removable,
  input wire logic                 removable_override,
  input wire logic [3:0]           port_in_use,
  input wire logic [7:0]           rd_data
);
  import hpc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Accepted write and read with address
  wire we = wr_req.wr && src_mode != HPC_SRC_PINS;
  wire [8:0] wa = {we, wr_req.addr};
  wire [8:0] ra = {rd_req.rd, rd_req.addr};
  wire [3:0] wd = wr_req.data[3:0];
  // Effects
  a_charge_wr: assert property (wa==9'h106 |=> charge_port_enable==$past(wd))
    else $error("charge wr");
  a_pins_ro: assert property (wr_req.wr && !we |=> $stable(charge_port_enable))
    else $error("pins wr");
  a_rmv_wr: assert property (wa==9'h107 && wr_req.data[7] |=> port_removable==$past(wd))
    else $error("rmv wr");
  a_rmv_otp: assert property (!removable_override ##1 !removable_override
    |-> port_removable==~$past(otp_non_removable)) else $error("rmv otp");
  a_used_wr: assert property (wa==9'h108 |=> port_in_use==$past(wd))
    else $error("used wr");
  a_rd_chg: assert property (ra==9'h106 |=> rd_data=={4'h0,charge_port_enable})
    else $error("charge rd");
  a_rd_rmv: assert property (ra==9'h107 |=>
    rd_data=={removable_override,3'h0,port_removable}) else $error("rmv rd");
  a_strap_load: assert property ($fell(sys_rst) |=>
    charge_port_enable==$past(power_charge_strap_pins)) else $error("strap load");
  a_rd_used: assert property (ra==9'h108 |=> rd_data=={4'h0,port_in_use})
    else $error("used rd");
  c_ovr: cover property (removable_override);
  c_pins: cover property (wr_req.wr && !we);
  c_unmap: cover property (ra==9'h109);
  c_strap: cover property ($fell(sys_rst));
endmodule : hpc_regs_mon
bind hpc_regs hpc_regs_mon mon (
  .clk                     (clk),
  .sys_rst                 (sys_rst),
  .src_mode                (src_mode),
  .wr_req                  (wr_req),
  .rd_req                  (rd_req),
  .power_charge_strap_pins (power_charge_strap_pins),
  .otp_non_removable       (otp_non_removable),
  .charge_port_enable      (charge_port_enable),
  .port_removable          (port_removable),
  .removable_override      (removable_override),
  .port_in_use             (port_in_use),
  .rd_data                 (rd_data)
);

// [tb/hpc_regs_tb_top.sv]
`timescale 1ns/1ps
// ======
// Bench
module hpc_regs_tb_top;
  import hpc_pkg::*;
  logic clk = 0, sys_rst = 1, removable_override;
  hpc_src_type src_mode = HPC_SRC_PINS;
  logic [3:0] power_charge_strap_pins = 4'hA, otp_non_removable = 4'h3;
  logic [3:0] charge_port_enable, port_removable, port_in_use;
  logic [7:0] rd_data, device_config_second;
  hpc_wr_type wr_req;
  hpc_rd_type rd_req;
  int errors = 0, check_count = 0, cyc = 0;
  // Address, write data, expected read
  logic [23:0] rows [6] = '{24'h06FF0F, 24'h078585, 24'h077A0C, 24'h08F505, 24'h0A5C5C, 24'h09FF00};
  always #12.5 clk = ~clk;
  hpc_host h (.clk(clk), .w(wr_req), .r(rd_req));
  hpc_regs uut (
    .clk                     (clk),
    .sys_rst                 (sys_rst),
    .src_mode                (src_mode),
    .power_charge_strap_pins (power_charge_strap_pins),
    .otp_non_removable       (otp_non_removable),
    .wr_req                  (wr_req),
    .rd_req                  (rd_req),
    .rd_data                 (rd_data),
    .charge_port_enable      (charge_port_enable),
    .port_removable          (port_removable),
    .removable_override      (removable_override),
    .port_in_use             (port_in_use),
    .device_config_second    (device_config_second)
  );
  // Compare a byte
  task chk(input logic [7:0] g, e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Verdict
  task test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // Hang guard
  always @(posedge clk) if (++cyc > 2000) begin
    errors++;
    test_done;
  end
  // Tests
  initial begin
    repeat (16) @(posedge clk);
    #1 sys_rst = 0;
    repeat (2) @(posedge clk);
    #1 chk({4'h0, charge_port_enable}, 8'h0A);
    chk({4'h0, port_removable}, 8'h0C);
    h.x(0, 8'h08, 0);
    chk(rd_data, 8'h0F);
    $display("reset test done");
    foreach (rows[i]) begin
      src_mode = i < 3 ? HPC_SRC_EEPROM : HPC_SRC_SMBUS;
      h.x(1, rows[i][23:16], rows[i][15:8]);
      h.x(0, rows[i][23:16], 0);
      chk(rd_data, rows[i][7:0]);
    end
    $display("row test done");
    h.x(1, 8'h08, 8'hF0);
    h.x(0, 8'h08, 0);
    chk(rd_data, 8'h01);
    chk({4'h0, port_in_use}, 8'h01);
    chk(device_config_second, 8'h5C);
    h.x(1, 8'h07, 8'h83);
    chk({removable_override, 3'h0, port_removable}, 8'h83);
    src_mode = HPC_SRC_PINS;
    h.x(1, 8'h06, 8'h00);
    h.x(0, 8'h06, 0);
    chk(rd_data, 8'h0F);
    $display("pins test done");
    // Reset in mid-run with new straps and OTP bits
    sys_rst = 1;
    power_charge_strap_pins = 4'h5;
    otp_non_removable = 4'hA;
    @(posedge clk) #1;
    chk({removable_override, 3'h0, port_removable}, 8'h00);
    chk({port_in_use, charge_port_enable}, 8'hF0);
    sys_rst = 0;
    repeat (2) @(posedge clk);
    #1 chk({4'h0, charge_port_enable}, 8'h05);
    chk({4'h0, port_removable}, 8'h05);
    $display("mid reset test done");
    test_done;
  end
endmodule : hpc_regs_tb_top
